/* dv/host_model.sv */
// host processor model that issues single-cycle i/o writes
`timescale 1ns/1ps
module host_model (
    input  wire logic       mclk_i,
    output logic            io_wr_o,
    output logic [7:0]      io_addr_o,
    output logic [7:0]      io_data_o
);
    initial begin
        io_wr_o = 1'b0;
        io_addr_o = 8'h00;
        io_data_o = 8'h00;
    end
    // the caller orders words: direction after mode 3, mask after bit 4 in mode 3
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        io_wr_o = 1'b1;
        io_addr_o = a;
        io_data_o = d;
        @(negedge mclk_i);
        io_wr_o = 1'b0;
        // a released bus must not keep showing the last word
        io_addr_o = ~a;
        io_data_o = ~d;
    endtask : wr
endmodule : host_model

/* dv/tb_top.sv */
// self-checking bench for the port control word decoder
`timescale 1ns/1ps
module tb_top;
    logic mclk_i, srst_i, io_wr, fetch_n, ack, en, req;
    logic [7:0] io_addr, io_data, port_in, dir, mask, vec;
    logic [1:0] mode, cond;
    int failures, tests_run;
    host_model i_host (.mclk_i(mclk_i), .io_wr_o(io_wr), .io_addr_o(io_addr),
        .io_data_o(io_data));
    parallel_port_unit #(.CMD_ADDR(8'h1D)) i_parallel_port_unit (.mclk_i(mclk_i),
        .srst_i(srst_i), .io_wr_i(io_wr), .io_addr_i(io_addr), .io_data_i(io_data),
        .port_in_i(port_in), .opcode_fetch_strobe_n_i(fetch_n), .irq_ack_i(ack),
        .port_mode_o(mode), .line_direction_o(dir), .irq_monitor_mask_o(mask),
        .irq_vector_o(vec), .irq_condition_o(cond), .irq_enable_o(en), .irq_req_o(req));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic w(input logic [7:0] d);
        i_host.wr(8'h1D, d);
        @(negedge mclk_i);
    endtask : w
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : cyc
    task automatic t_reset();
        chk("mode", 8'h01, {6'h00, mode});
        chk("dir", 8'hFF, dir);
        chk("mask", 8'hFF, mask);
        chk("vec", 8'h00, vec);
        chk("cond_en_req", 8'h00, {4'h0, cond, en, req});
        $display("t_reset done");
    endtask : t_reset
    task automatic t_mode3();
        w(8'h02);
        chk("vec", 8'h02, vec);
        i_host.wr(8'h1C, 8'h55);
        chk("vec", 8'h02, vec);
        w(8'hCF);
        chk("mode", 8'h03, {6'h00, mode});
        w(8'h62);
        chk("dir", 8'h62, dir);
        w(8'hF7);
        chk("cond", 8'h07, {5'h00, cond, en});
        w(8'h9F);
        chk("mask", 8'h9F, mask);
        $display("t_mode3 done");
    endtask : t_mode3
    task automatic t_and();
        port_in = 8'h40;
        cyc(2);
        chk("req", 8'h00, {7'h00, req});
        port_in = 8'h60;
        cyc(2);
        chk("req", 8'h01, {7'h00, req});
        port_in = 8'h00;
        ack = 1'b1;
        cyc(1);
        ack = 1'b0;
        cyc(1);
        chk("req", 8'h00, {7'h00, req});
        $display("t_and done");
    endtask : t_and
    task automatic t_or();
        w(8'hB7);
        w(8'hFD);
        chk("cond", 8'h01, {6'h00, cond});
        port_in = 8'hFD;
        cyc(2);
        chk("req", 8'h00, {7'h00, req});
        fetch_n = 1'b0;
        port_in = 8'hFF;
        cyc(3);
        chk("req", 8'h00, {7'h00, req});
        fetch_n = 1'b1;
        cyc(2);
        chk("req", 8'h01, {7'h00, req});
        w(8'h97);
        chk("req", 8'h00, {7'h00, req});
        w(8'hFF);
        chk("mask", 8'hFF, mask);
        w(8'h03);
        chk("en", 8'h00, {5'h00, cond, en});
        $display("t_or done");
    endtask : t_or
    task automatic t_other();
        w(8'h4F);
        w(8'hF7);
        chk("cond", 8'h01, {5'h00, cond, en});
        w(8'hA0);
        chk("vec", 8'hA0, vec);
        w(8'h8F);
        chk("mode", 8'h02, {6'h00, mode});
        w(8'h04);
        chk("vec", 8'h04, vec);
        $display("t_other done");
    endtask : t_other
    task automatic summarize();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    initial begin
        #50000;
        failures++;
        summarize();
    end
    initial begin
        srst_i = 1'b1;
        port_in = 8'h00;
        fetch_n = 1'b1;
        ack = 1'b0;
        cyc(3);
        srst_i = 1'b0;
        t_reset();
        t_mode3();
        t_and();
        t_or();
        t_other();
        srst_i = 1'b1;
        cyc(2);
        srst_i = 1'b0;
        t_reset();
        summarize();
    end
endmodule : tb_top

/* logic/parallel_port_unit.sv */
// control word decode, mode-3 interrupt condition for one 8-bit port
`timescale 1ns/1ps
`include "pport_params.svh"

module parallel_port_unit
    import pport_pkg::*;
#(
    parameter logic [7:0] CMD_ADDR = `ADDR_A_CMD
) (
    input  wire logic       mclk_i,
    input  wire logic       srst_i,
    input  wire logic       io_wr_i,
    input  wire logic [7:0] io_addr_i,
    input  wire logic [7:0] io_data_i,
    input  wire logic [7:0] port_in_i,
    input  wire logic       opcode_fetch_strobe_n_i,
    input  wire logic       irq_ack_i,
    output logic [1:0]      port_mode_o,
    output logic [7:0]      line_direction_o,
    output logic [7:0]      irq_monitor_mask_o,
    output logic [7:0]      irq_vector_o,
    output logic [1:0]      irq_condition_o,
    output logic            irq_enable_o,
    output logic            irq_req_o
);

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    logic [1:0]  mode_r;
    logic [7:0]  dir_r;
    logic [7:0]  mask_r;
    logic [7:0]  vec_r;
    logic [1:0]  cond_r;
    logic        ien_r;
    logic        pend_r;
    logic        m1_prev_r;
    wr_state_e   st_r;
    wr_state_e   st_nxt;

    wire cmd_wr    = io_wr_i && (io_addr_i == CMD_ADDR);
    wire wr_idle   = cmd_wr && (st_r == ST_IDLE);
    wire is_vec    = wr_idle && !io_data_i[`BIT_VEC];
    wire is_mode   = wr_idle && (io_data_i[`FLD_CMD] == `CMD_NIB_MODE);
    wire is_setup  = wr_idle && (io_data_i[`FLD_CMD] == `CMD_NIB_ISETUP);
    wire is_ienonly= wr_idle && (io_data_i[`FLD_CMD] == `CMD_NIB_IEN);
    wire is_dir    = cmd_wr && (st_r == ST_DIR);
    wire is_mask   = cmd_wr && (st_r == ST_MASK);
    wire in_bit    = (mode_r == `MODE_BIT);
    wire mode_bit_w= (io_data_i[`FLD_MODE] == `MODE_BIT);
    // bit 4 acts as clear in any mode, but chains the mask only in mode 3
    wire setup_clr = is_setup && io_data_i[`BIT_MASKFOL];
    wire setup_m3  = is_setup && in_bit;

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE: begin
                if (is_mode && mode_bit_w) begin
                    st_nxt = ST_DIR;
                end else if (setup_m3 && io_data_i[`BIT_MASKFOL]) begin
                    st_nxt = ST_MASK;
                end
            end
            ST_DIR: begin
                if (cmd_wr) st_nxt = ST_IDLE;
            end
            ST_MASK: begin
                if (cmd_wr) st_nxt = ST_IDLE;
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    // ----------------------------------------
    // interrupt condition
    // ----------------------------------------
    // lines at the chosen level; output lines and mask ones drop out
    wire [7:0] act_lvl   = cond_r[0] ? port_in_i : ~port_in_i;
    wire [7:0] monitored = dir_r & ~mask_r;
    wire       any_hit   = |(act_lvl & monitored);
    wire       all_hit   = (monitored != `BYTE_ZERO) &&
                           ((act_lvl & monitored) == monitored);
    wire       cond_true = in_bit && (cond_r[1] ? all_hit : any_hit);
    wire       m1_low    = !opcode_fetch_strobe_n_i;
    // a new request is held off while the fetch strobe is low
    wire       raise     = ien_r && cond_true && !m1_low && !pend_r;

    // strobe rising edge, where a held-off request must come out
    wire       m1_rise   = !m1_prev_r && opcode_fetch_strobe_n_i;

    // ----------------------------------------
    // next values
    // ----------------------------------------
    // every register but pend_r and m1_prev_r holds unless its own decode strobe fires this cycle
    wire [1:0] mode_nxt  = is_mode ? io_data_i[`FLD_MODE] : mode_r;
    wire [7:0] dir_nxt   = is_dir ? io_data_i : dir_r;
    wire [7:0] mask_nxt  = is_mask ? io_data_i : mask_r;
    wire [7:0] vec_nxt   = is_vec ? io_data_i : vec_r;
    wire [1:0] setup_fld = {io_data_i[`BIT_ANDOR], io_data_i[`BIT_HILO]};
    wire [1:0] cond_nxt  = setup_m3 ? setup_fld : cond_r;
    wire       ien_wr    = is_setup || is_ienonly;
    wire       ien_nxt   = ien_wr ? io_data_i[`BIT_IEN] : ien_r;
    // set acts only while pend_r is low, so a clear drops pend_r and a condition still met raises it again one cycle later
    wire       pend_clr  = setup_clr || irq_ack_i;
    wire       pend_nxt  = raise || (pend_r && !pend_clr);

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            st_r <= ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            mode_r <= `MODE_RST;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            dir_r <= `BYTE_ONES;
        end else begin
            dir_r <= dir_nxt;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            mask_r <= `BYTE_ONES;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            vec_r <= `BYTE_ZERO;
        end else begin
            vec_r <= vec_nxt;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cond_r <= `COND_RST;
        end else begin
            cond_r <= cond_nxt;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ien_r <= 1'b0;
        end else begin
            ien_r <= ien_nxt;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            pend_r <= 1'b0;
        end else begin
            pend_r <= pend_nxt;
        end
    end

    // resets to the strobe's idle level so no false rise follows reset
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            m1_prev_r <= 1'b1;
        end else begin
            m1_prev_r <= opcode_fetch_strobe_n_i;
        end
    end

    assign port_mode_o        = mode_r;
    assign line_direction_o   = dir_r;
    assign irq_monitor_mask_o = mask_r;
    assign irq_vector_o       = vec_r;
    assign irq_condition_o    = cond_r;
    assign irq_enable_o       = ien_r;
    assign irq_req_o          = pend_r && ien_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // decode and register loads
    mode_store_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        is_mode |=> (mode_r == $past(io_data_i[`FLD_MODE])))
        else $error("mode not stored");
    dir_follow_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        (is_mode && mode_bit_w) |=> (st_r == ST_DIR))
        else $error("direction word not expected after mode 3");
    dir_only_m3_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        (is_mode && !mode_bit_w) |=> (st_r == ST_IDLE))
        else $error("direction word expected outside mode 3");
    dir_load_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        is_dir |=> (dir_r == $past(io_data_i)) && (st_r == ST_IDLE))
        else $error("direction word not taken");
    dir_keep_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        !is_dir |=> $stable(dir_r))
        else $error("direction changed without its word");
    cond_keep_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        (is_setup && !in_bit) |=> $stable(cond_r))
        else $error("setup applied outside mode 3");
    cond_store_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        setup_m3 |=> (cond_r[1] == $past(io_data_i[`BIT_ANDOR])) &&
                     (cond_r[0] == $past(io_data_i[`BIT_HILO])))
        else $error("setup bits not retained");
    mask_follow_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        (setup_m3 && io_data_i[`BIT_MASKFOL]) |=> (st_r == ST_MASK))
        else $error("mask word not expected");
    mask_chain_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        (is_setup && !in_bit) |=> (st_r == ST_IDLE))
        else $error("mask chained outside mode 3");
    mask_load_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        is_mask |=> (mask_r == $past(io_data_i)) && (st_r == ST_IDLE))
        else $error("mask word not taken");
    mask_keep_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        !is_mask |=> $stable(mask_r))
        else $error("mask changed without its word");
    ien_store_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        (is_setup || is_ienonly) |=> (ien_r == $past(io_data_i[`BIT_IEN])))
        else $error("enable bit not taken");
    ien_only_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        is_ienonly |=> (ien_r == $past(io_data_i[`BIT_IEN])) && $stable(cond_r) &&
                       $stable(mask_r))
        else $error("enable word misapplied");
    cmd_addr_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        (io_wr_i && (io_addr_i != CMD_ADDR)) |=> $stable(mode_r) && $stable(vec_r) &&
                                               $stable(st_r))
        else $error("write at other address decoded");
    vec_store_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        is_vec |=> (vec_r == $past(io_data_i)))
        else $error("vector word not stored");

    // pending request clear and hold
    clr_pend_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        (setup_clr && !raise) |=> !pend_r)
        else $error("pending not cleared");
    ack_clr_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        (irq_ack_i && !raise) |=> !pend_r)
        else $error("pending not cleared by acknowledge");
    pend_hold_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        (pend_r && !pend_clr) |=> pend_r)
        else $error("pending dropped without a clear");

    // request condition and its masking
    or_raise_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        (ien_r && in_bit && !cond_r[1] && any_hit && !m1_low && !irq_ack_i && !setup_clr)
        |=> pend_r)
        else $error("or condition missed");
    or_idle_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        (in_bit && !cond_r[1] && !any_hit && !pend_r) |=> !pend_r)
        else $error("or request without an active line");
    and_raise_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        (ien_r && in_bit && cond_r[1] && all_hit && !m1_low && !irq_ack_i && !setup_clr)
        |=> pend_r)
        else $error("and condition missed");
    and_wait_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        (cond_r[1] && !all_hit && !pend_r) |=> !pend_r)
        else $error("and request with a line idle");
    masked_line_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        ((mask_r == `BYTE_ONES) && !pend_r && !setup_m3) |=> !pend_r)
        else $error("masked lines raised request");
    no_input_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        (((dir_r & ~mask_r) == `BYTE_ZERO) && !pend_r) |=> !pend_r)
        else $error("request with no monitored input");
    m3_only_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        (!in_bit && !pend_r) |=> !pend_r)
        else $error("request outside mode 3");

    // fetch strobe deferral and output gating
    m1_defer_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        (m1_low && !pend_r) |=> !pend_r)
        else $error("request during fetch strobe");
    m1_release_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        (m1_rise && ien_r && cond_true && !pend_r) |=> pend_r)
        else $error("request not released at strobe rise");
    req_gate_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        !ien_r |-> !irq_req_o)
        else $error("request shown while disabled");

endmodule : parallel_port_unit

/* logic/pport_params.svh */
// constants for the parallel port control word decoder
`ifndef PPORT_PARAMS_SVH
`define PPORT_PARAMS_SVH
`define ADDR_A_DATA     8'h1C
`define ADDR_A_CMD      8'h1D
`define ADDR_B_DATA     8'h1E
`define ADDR_B_CMD      8'h1F
`define MODE_BIT        2'h3
`define MODE_BIDIR      2'h2
`define MODE_RST        2'h1
`define CMD_NIB_MODE    4'hF
`define CMD_NIB_ISETUP  4'h7
`define CMD_NIB_IEN     4'h3
`define BIT_IEN         7
`define BIT_ANDOR       6
`define BIT_HILO        5
`define BIT_MASKFOL     4
`define BIT_VEC         0
`define FLD_CMD         3:0
`define FLD_MODE        7:6
`define COND_RST        2'h0
`define BYTE_ZERO       8'h00
`define BYTE_ONES       8'hFF
`endif

/* logic/pport_pkg.sv */
// types for the parallel port control word decoder
package pport_pkg;
    // gray order: normal, expect direction, expect mask
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DIR  = 2'b01,
        ST_MASK = 2'b11
    } wr_state_e;
endpackage : pport_pkg
